// [inc/plc_pkg.sv]
package plc_pkg;
	localparam logic [15:0] ETHERTYPE_PL   = 16'h88AB;
	localparam logic [10:0] OFS_ETYPE_HI   = 11'h00C;
	localparam logic [10:0] OFS_ETYPE_LO   = 11'h00D;
	localparam logic [10:0] OFS_MTYPE      = 11'h00E;
	localparam logic [10:0] OFS_DST        = 11'h00F;
	localparam logic [10:0] OFS_SRC        = 11'h010;
	localparam logic [10:0] OFS_DATA0      = 11'h011;
	localparam logic [10:0] OFS_DATA1      = 11'h012;
	localparam logic [6:0]  MT_SOC         = 7'h01;
	localparam logic [6:0]  MT_PREQ        = 7'h03;
	localparam logic [6:0]  MT_PRES        = 7'h04;
	localparam logic [6:0]  MT_SOA         = 7'h05;
	localparam logic [6:0]  MT_ASND        = 7'h06;
	localparam logic [7:0]  NODE_BCAST     = 8'hFF;
	localparam logic [7:0]  SVC_NONE       = 8'h00;
	localparam logic [7:0]  SVC_NMT_CMD    = 8'h04;
	localparam logic [7:0]  CMD_START      = 8'h21;
	localparam logic [7:0]  CMD_STOP       = 8'h22;
	localparam logic [7:0]  CMD_PREOP2     = 8'h23;
	localparam logic [7:0]  CMD_EN_RDY     = 8'h24;
	localparam logic [7:0]  CMD_RESET      = 8'h28;
	localparam int          CLK_HZ         = 125_000_000;
	localparam int          CYC_PER_MS     = CLK_HZ / 1000;
	localparam int          BLINK_MS       = 200;
	localparam int          FLICKER_MS     = 50;
	localparam int          FLASH_ON_MS    = 200;
	localparam int          FLASH_OFF_MS   = 200;
	localparam int          FLASH_GAP_MS   = 1000;
	localparam int          NA_TIMEOUT_MS  = 100;
	localparam logic [31:0] BLINK_CYC      = 32'(BLINK_MS * CYC_PER_MS);
	localparam logic [31:0] FLICKER_CYC    = 32'(FLICKER_MS * CYC_PER_MS);
	localparam logic [31:0] FLASH_ON_CYC   = 32'(FLASH_ON_MS * CYC_PER_MS);
	localparam logic [31:0] FLASH_OFF_CYC  = 32'(FLASH_OFF_MS * CYC_PER_MS);
	localparam logic [31:0] FLASH_GAP_CYC  = 32'(FLASH_GAP_MS * CYC_PER_MS);
	localparam logic [31:0] NA_TIMEOUT_CYC = 32'(NA_TIMEOUT_MS * CYC_PER_MS);

	typedef enum logic [6:0] {
		ST_NOT_ACTIVE = 7'h01,
		ST_PREOP1     = 7'h02,
		ST_PREOP2     = 7'h04,
		ST_READY      = 7'h08,
		ST_OPER       = 7'h10,
		ST_STOPPED    = 7'h20,
		ST_BASIC_ETH  = 7'h40
	} plc_state_t;

	typedef enum logic [2:0] {
		LED_OFF    = 3'h0,
		LED_SINGLE = 3'h1,
		LED_DOUBLE = 3'h2,
		LED_TRIPLE = 3'h3,
		LED_SOLID  = 3'h4,
		LED_BLINK  = 3'h5,
		LED_FLICK  = 3'h6
	} plc_led_t;
endpackage : plc_pkg

// [inc/plc_rx_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface plc_rx_if;
	logic       evt;
	logic [6:0] mtype;
	logic [7:0] dst;
	logic [7:0] src;
	logic [7:0] d0;
	logic [7:0] d1;
	logic       pd_valid;
	logic [7:0] pd_data;
	logic [6:0] cur_type;
	modport parser (output evt, mtype, dst, src, d0, d1, pd_valid, pd_data, cur_type);
	modport nmt (input evt, mtype, dst, src, d0, d1, pd_valid, pd_data, cur_type);
endinterface : plc_rx_if
`default_nettype wire

// [rtl/plc_frame_parser.sv]
`timescale 1ns/1ps
`default_nettype none
module plc_frame_parser
	import plc_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   rst,
	input  wire logic   rx_valid,
	input  wire logic   rx_sof,
	input  wire logic [7:0] rx_data,
	input  wire logic   rx_eof,
	input  wire logic   rx_crc_ok,
	plc_rx_if.parser    rxo
);
	typedef struct packed {
		logic [10:0] cnt;
		logic        ok;
		logic [6:0]  mtype;
		logic [7:0]  dst;
		logic [7:0]  src;
		logic [7:0]  d0;
		logic [7:0]  d1;
		logic        evt;
		logic        pdv;
		logic [7:0]  pdd;
	} plc_prs_t;

	plc_prs_t s_q, s_d;
	logic     known;
	logic [10:0] idx;

	always_comb begin
		s_d = s_q;
		s_d.evt = 1'b0;
		s_d.pdv = 1'b0;
		idx = rx_sof ? 11'h000 : s_q.cnt;
		known = (s_q.mtype == MT_SOC) || (s_q.mtype == MT_PREQ) || (s_q.mtype == MT_PRES)
			|| (s_q.mtype == MT_SOA) || (s_q.mtype == MT_ASND);
		if (rx_valid) begin
			if (rx_sof)
				s_d.ok = 1'b1;
			if (s_q.cnt != 11'h7FF)
				s_d.cnt = idx + 11'h001;
			if (idx == OFS_ETYPE_HI && rx_data != ETHERTYPE_PL[15:8])
				s_d.ok = 1'b0;
			if (idx == OFS_ETYPE_LO && rx_data != ETHERTYPE_PL[7:0])
				s_d.ok = 1'b0;
			if (idx == OFS_MTYPE)
				s_d.mtype = rx_data[6:0];
			if (idx == OFS_DST)
				s_d.dst = rx_data;
			if (idx == OFS_SRC)
				s_d.src = rx_data;
			if (idx == OFS_DATA0)
				s_d.d0 = rx_data;
			if (idx == OFS_DATA1)
				s_d.d1 = rx_data;
			if (idx >= OFS_DATA0 && s_q.ok) begin
				s_d.pdv = 1'b1;
				s_d.pdd = rx_data;
			end
		end
		// crc errors and short frames never reach the state machine
		if (rx_eof) begin
			s_d.evt = s_q.ok && known && rx_crc_ok && (s_q.cnt > OFS_SRC);
			s_d.ok  = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign rxo.evt      = s_q.evt;
	assign rxo.mtype    = s_q.mtype;
	assign rxo.dst      = s_q.dst;
	assign rxo.src      = s_q.src;
	assign rxo.d0       = s_q.d0;
	assign rxo.d1       = s_q.d1;
	assign rxo.pd_valid = s_q.pdv;
	assign rxo.pd_data  = s_q.pdd;
	assign rxo.cur_type = s_q.mtype;
endmodule : plc_frame_parser
`default_nettype wire

// [rtl/plc_led_flash.sv]
`timescale 1ns/1ps
`default_nettype none
module plc_led_flash
	import plc_pkg::*;
#(
	parameter logic [31:0] ON_CYC    = FLASH_ON_CYC,
	parameter logic [31:0] OFF_CYC   = FLASH_OFF_CYC,
	parameter logic [31:0] GAP_CYC   = FLASH_GAP_CYC,
	parameter logic [31:0] BLINK_LEN = BLINK_CYC,
	parameter logic [31:0] FLICK_LEN = FLICKER_CYC
) (
	input  wire logic   clk,
	input  wire logic   rst,
	input  wire plc_pkg::plc_led_t pattern,
	output logic        led
);
	typedef struct packed {
		plc_led_t    pat;
		logic [31:0] cnt;
		logic [1:0]  k;
		logic        led;
	} plc_led_st_t;

	plc_led_st_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.pat = pattern;
		if (pattern != s_q.pat) begin
			// restart so each state's pattern begins with a clean first flash
			s_d.cnt = '0;
			s_d.k   = 2'h0;
			s_d.led = 1'b0;
		end else if (s_q.cnt != '0) begin
			s_d.cnt = s_q.cnt - 32'h1;
		end else begin
			case (pattern)
				LED_OFF:   s_d.led = 1'b0;
				LED_SOLID: s_d.led = 1'b1;
				LED_BLINK: begin
					s_d.led = !s_q.led;
					s_d.cnt = BLINK_LEN - 32'h1;
				end
				LED_FLICK: begin
					s_d.led = !s_q.led;
					s_d.cnt = FLICK_LEN - 32'h1;
				end
				LED_SINGLE, LED_DOUBLE, LED_TRIPLE: begin
					if (!s_q.led) begin
						s_d.led = 1'b1;
						s_d.cnt = ON_CYC - 32'h1;
					end else begin
						s_d.led = 1'b0;
						if (s_q.k + 2'h1 == 2'(pattern)) begin
							s_d.k   = 2'h0;
							s_d.cnt = GAP_CYC - 32'h1;
						end else begin
							s_d.k   = s_q.k + 2'h1;
							s_d.cnt = OFF_CYC - 32'h1;
						end
					end
				end
				default: s_d.led = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			s_q <= '{pat: LED_OFF, cnt: 32'h0, k: 2'h0, led: 1'b0};
		else
			s_q <= s_d;
	end

	assign led = s_q.led;
endmodule : plc_led_flash
`default_nettype wire

// [rtl/plc_cn_nmt.sv]
// Operation
// - addressed node answers poll with response
// - async payloads ride in async send frames
// - async period: one sender, one message
// - no invitation means no async send follows
// - async phase timed from start-async to response
// - not-active: listen only, see resets, led off
// - not-active to preop1 on start-async or cycle
// - not-active to basic ethernet on timeout
// - preop1: send only when invited, single flash
// - identification in preop1, may continue preop2
// - preop1 to preop2 on start-of-cycle
// - preop2: accept polls, drop data, double flash
// - preop2: answer invitations only; ready answers polls too
// - preop2 to ready: enable command plus app ready
// - error in preop2 or ready returns preop1
// - stop command in preop2 or ready stops
// - ready: answer polls, triple flash, start operates
// - start-of-cycle type 01h begins each cycle
// - accept frame only with ethertype 88ABh
// - header: reserved, type, destination, source, data
// - basic ethernet: cycle frame halts tx, preop1
`timescale 1ns/1ps
`default_nettype none
module plc_cn_nmt
	import plc_pkg::*;
#(
	parameter logic [7:0]  NODE_ID    = 8'h01,
	parameter logic [31:0] NA_TIMEOUT = NA_TIMEOUT_CYC,
	parameter logic [31:0] ON_CYC     = FLASH_ON_CYC,
	parameter logic [31:0] OFF_CYC    = FLASH_OFF_CYC,
	parameter logic [31:0] GAP_CYC    = FLASH_GAP_CYC,
	parameter logic [31:0] BLINK_LEN  = BLINK_CYC,
	parameter logic [31:0] FLICK_LEN  = FLICKER_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        rx_valid,
	input  wire logic        rx_sof,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_eof,
	input  wire logic        rx_crc_ok,
	input  wire logic        app_ready,
	input  wire logic        err_detect,
	output logic             tx_pres,
	output logic             tx_async,
	output logic             tx_legacy_en,
	output logic             pdo_valid,
	output logic [7:0]       pdo_data,
	output logic             cycle_start,
	output logic             ident_req,
	output plc_pkg::plc_state_t nmt_state,
	output logic             module_status_led
);
	typedef struct packed {
		plc_state_t  st;
		logic [31:0] to_cnt;
		logic        en_rdy;
		logic        pres;
		logic        asyn;
		logic        legacy;
		logic        pdv;
		logic [7:0]  pdd;
		logic        soc;
		logic        ident;
		plc_led_t    pat;
	} plc_nmt_t;

	plc_rx_if rx ();

	plc_frame_parser u_parser (
		.clk       (clk),
		.rst       (rst),
		.rx_valid  (rx_valid),
		.rx_sof    (rx_sof),
		.rx_data   (rx_data),
		.rx_eof    (rx_eof),
		.rx_crc_ok (rx_crc_ok),
		.rxo       (rx)
	);

	plc_nmt_t s_q, s_d;

	logic is_soc;
	logic is_preq;
	logic is_pres;
	logic is_soa;
	logic is_asnd;
	logic cyc_frame;
	logic for_me;
	logic invited;
	logic nmt_cmd;
	logic pd_keep;

	always_comb begin
		is_soc  = rx.evt && rx.mtype == MT_SOC;
		is_preq = rx.evt && rx.mtype == MT_PREQ && rx.dst == NODE_ID;
		is_pres = rx.evt && rx.mtype == MT_PRES;
		is_soa  = rx.evt && rx.mtype == MT_SOA;
		is_asnd = rx.evt && rx.mtype == MT_ASND;
		cyc_frame = is_soc || is_pres || is_soa
			|| (rx.evt && rx.mtype == MT_PREQ);
		for_me  = rx.dst == NODE_ID || rx.dst == NODE_BCAST;
		// an empty service field grants nobody, so no async send may follow
		// the single answer closes the async phase right behind the start-async
		invited = is_soa && rx.d0 != SVC_NONE && rx.d1 == NODE_ID;
		nmt_cmd = is_asnd && for_me && rx.d0 == SVC_NMT_CMD;
		// process data only reaches the application once operational
		pd_keep = rx.pd_valid && s_q.st == ST_OPER
			&& (rx.cur_type == MT_PREQ || rx.cur_type == MT_PRES)
			&& (rx.cur_type == MT_PRES || rx.dst == NODE_ID);
	end

	always_comb begin
		s_d = s_q;
		s_d.pres  = 1'b0;
		s_d.asyn  = 1'b0;
		s_d.soc   = is_soc;
		s_d.ident = 1'b0;
		s_d.pdv   = pd_keep;
		if (pd_keep)
			s_d.pdd = rx.pd_data;
		if (nmt_cmd && rx.d1 == CMD_EN_RDY)
			s_d.en_rdy = 1'b1;
		case (s_q.st)
			ST_NOT_ACTIVE: begin
				s_d.pat    = LED_OFF;
				s_d.legacy = 1'b0;
				if (cyc_frame)
					s_d.to_cnt = NA_TIMEOUT;
				else if (s_q.to_cnt != '0)
					s_d.to_cnt = s_q.to_cnt - 32'h1;
				if (is_soc || is_soa)
					s_d.st = ST_PREOP1;
				else if (s_q.to_cnt == 32'h1 && !cyc_frame)
					s_d.st = ST_BASIC_ETH;
			end
			ST_PREOP1: begin
				s_d.pat = LED_SINGLE;
				s_d.asyn = invited;
				// identification and config may carry over into preop2
				s_d.ident = invited;
				if (is_soc) begin
					s_d.st = ST_PREOP2;
					s_d.en_rdy = 1'b0;
				end
			end
			ST_PREOP2: begin
				s_d.pat  = LED_DOUBLE;
				s_d.asyn = invited;
				s_d.ident = invited;
				if (err_detect)
					s_d.st = ST_PREOP1;
				else if (nmt_cmd && rx.d1 == CMD_STOP)
					s_d.st = ST_STOPPED;
				else if (s_q.en_rdy && app_ready)
					s_d.st = ST_READY;
			end
			ST_READY: begin
				s_d.pat  = LED_TRIPLE;
				s_d.asyn = invited;
				s_d.pres = is_preq;
				if (err_detect)
					s_d.st = ST_PREOP1;
				else if (nmt_cmd && rx.d1 == CMD_STOP)
					s_d.st = ST_STOPPED;
				else if (nmt_cmd && rx.d1 == CMD_START)
					s_d.st = ST_OPER;
			end
			ST_OPER: begin
				s_d.pat  = LED_SOLID;
				s_d.asyn = invited;
				s_d.pres = is_preq;
				if (err_detect)
					s_d.st = ST_PREOP1;
				else if (nmt_cmd && rx.d1 == CMD_STOP)
					s_d.st = ST_STOPPED;
				else if (nmt_cmd && rx.d1 == CMD_PREOP2)
					s_d.st = ST_PREOP2;
			end
			ST_STOPPED: begin
				s_d.pat  = LED_BLINK;
				s_d.asyn = invited;
				if (err_detect)
					s_d.st = ST_PREOP1;
				else if (nmt_cmd && rx.d1 == CMD_PREOP2)
					s_d.st = ST_PREOP2;
			end
			ST_BASIC_ETH: begin
				s_d.pat    = LED_FLICK;
				s_d.legacy = !cyc_frame;
				if (cyc_frame)
					s_d.st = ST_PREOP1;
			end
			default: s_d.st = ST_NOT_ACTIVE;
		endcase
		if (s_d.st != ST_BASIC_ETH)
			s_d.legacy = 1'b0;
		if (s_d.st == ST_PREOP2 && s_q.st != ST_PREOP2)
			s_d.en_rdy = 1'b0;
		// reset is honoured in every state, not-active included
		if (nmt_cmd && rx.d1 == CMD_RESET) begin
			s_d.st     = ST_NOT_ACTIVE;
			s_d.to_cnt = NA_TIMEOUT;
			s_d.pres   = 1'b0;
			s_d.asyn   = 1'b0;
			s_d.legacy = 1'b0;
			s_d.en_rdy = 1'b0;
			// pattern drops with the state so the led never lingers
			s_d.pat    = LED_OFF;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q        <= '0;
			s_q.st     <= ST_NOT_ACTIVE;
			s_q.to_cnt <= NA_TIMEOUT;
			s_q.pat    <= LED_OFF;
		end else begin
			s_q <= s_d;
		end
	end

	plc_led_flash #(
		.ON_CYC    (ON_CYC),
		.OFF_CYC   (OFF_CYC),
		.GAP_CYC   (GAP_CYC),
		.BLINK_LEN (BLINK_LEN),
		.FLICK_LEN (FLICK_LEN)
	) u_led (
		.clk     (clk),
		.rst     (rst),
		.pattern (s_q.pat),
		.led     (module_status_led)
	);

	assign tx_pres      = s_q.pres;
	assign tx_async     = s_q.asyn;
	assign tx_legacy_en = s_q.legacy;
	assign pdo_valid    = s_q.pdv;
	assign pdo_data     = s_q.pdd;
	assign cycle_start  = s_q.soc;
	assign ident_req    = s_q.ident;
	assign nmt_state    = s_q.st;
endmodule : plc_cn_nmt
`default_nettype wire

// [testbench/plc_cn_nmt_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module plc_cn_nmt_monitor
	import plc_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                tx_pres,
	input  wire logic                tx_async,
	input  wire logic                tx_legacy_en,
	input  wire logic                pdo_valid,
	input  wire logic                cycle_start,
	input  wire plc_pkg::plc_state_t nmt_state,
	input  wire logic                module_status_led
);
	import plc_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	na_quiet_a: assert property (nmt_state == ST_NOT_ACTIVE |-> !(tx_pres || tx_async))
		else $error("tx in not-active");
	// led may lag the state by one cycle, so only settled not-active counts
	na_led_a: assert property ($past(nmt_state) == ST_NOT_ACTIVE && nmt_state == ST_NOT_ACTIVE
		|-> !module_status_led) else $error("led on in not-active");
	pres_gate_a: assert property (tx_pres |-> nmt_state inside {ST_READY, ST_OPER})
		else $error("poll response outside ready");
	async_gate_a: assert property (tx_async |-> !(nmt_state inside {ST_NOT_ACTIVE, ST_BASIC_ETH}))
		else $error("async tx not allowed");
	legacy_gate_a: assert property (tx_legacy_en |-> nmt_state == ST_BASIC_ETH)
		else $error("legacy tx outside basic");
	pdo_gate_a: assert property (pdo_valid |-> nmt_state == ST_OPER)
		else $error("process data not discarded");
	async_once_a: assert property (tx_async |=> !tx_async)
		else $error("async pulse too long");
	pres_once_a: assert property (tx_pres |=> !tx_pres)
		else $error("response pulse too long");
	ready_entry_a: assert property ($rose(nmt_state == ST_READY) |-> $past(nmt_state) == ST_PREOP2)
		else $error("ready not from preop2");
	preop2_entry_a: assert property ($rose(nmt_state == ST_PREOP2) && $past(nmt_state) == ST_PREOP1
		|-> cycle_start) else $error("preop2 without cycle");
	basic_entry_a: assert property ($rose(nmt_state == ST_BASIC_ETH)
		|-> $past(nmt_state) == ST_NOT_ACTIVE) else $error("basic not from not-active");
	cover property (tx_pres);
	cover property (nmt_state == ST_BASIC_ETH);
	cover property (nmt_state == ST_STOPPED);
endmodule : plc_cn_nmt_monitor
bind plc_cn_nmt plc_cn_nmt_monitor i_mon (
	.clk(clk), .rst(rst), .tx_pres(tx_pres), .tx_async(tx_async),
	.tx_legacy_en(tx_legacy_en), .pdo_valid(pdo_valid), .cycle_start(cycle_start),
	.nmt_state(nmt_state), .module_status_led(module_status_led)
);
`default_nettype wire

// [testbench/plc_mn_model.sv]
`timescale 1ns/1ps
`default_nettype none
module plc_mn_model
	import plc_pkg::*;
(
	input  wire logic  clk,
	output logic       rx_valid,
	output logic       rx_sof,
	output logic [7:0] rx_data,
	output logic       rx_eof,
	output logic       rx_crc_ok
);
	initial begin
		rx_valid = 1'b0;
		rx_sof = 1'b0;
		rx_data = 8'h00;
		rx_eof = 1'b0;
		rx_crc_ok = 1'b0;
	end
	// one frame per call; caller orders cycle, polls, start-async, async send
	task automatic send(input logic [6:0] mt, input logic [7:0] dst, d0, d1,
		input logic [1:0] bad, input logic [31:0] fill);
		logic [7:0] b;
		for (int i = 0; i < 23; i++) begin
			case (i)
				12: b = bad[0] ? 8'h86 : ETHERTYPE_PL[15:8];
				13: b = ETHERTYPE_PL[7:0];
				14: b = {1'b0, mt};
				15: b = dst;
				16: b = 8'hF0;
				17: b = d0;
				18: b = d1;
				default: b = fill[8*(i%4)+:8] ^ 8'(i);
			endcase
			@(posedge clk);
			rx_valid <= 1'b1;
			rx_sof <= (i == 0);
			rx_data <= b;
		end
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_sof <= 1'b0;
		rx_data <= ~b;
		rx_eof <= 1'b1;
		rx_crc_ok <= !bad[1];
		@(posedge clk);
		rx_eof <= 1'b0;
		rx_crc_ok <= 1'b0;
	endtask : send
endmodule : plc_mn_model
`default_nettype wire

// [testbench/tb_plc_cn_nmt.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_plc_cn_nmt;
	import plc_pkg::*;
	localparam logic [7:0] ME = 8'h01;
	logic       clk, rst, app_ready, err_detect, rx_valid, rx_sof, rx_eof, rx_crc_ok;
	logic [7:0] rx_data, pdo_data;
	logic       tx_pres, tx_async, tx_legacy_en, pdo_valid, cycle_start, ident_req, led;
	plc_state_t nmt_state;
	logic [6:0] es;
	logic [7:0] exp_q[$];
	logic [7:0] got_q[$];
	logic [31:0] rs = 32'hAB6400B6;
	int         err_total, n_tests, cyc;
	plc_mn_model i_mn (.clk(clk), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_data(rx_data),
		.rx_eof(rx_eof), .rx_crc_ok(rx_crc_ok));
	// short counts keep the run small
	// stopped and basic-ethernet led timings keep their defaults, never timed here
	plc_cn_nmt #(.NODE_ID(ME), .NA_TIMEOUT(32'd120), .ON_CYC(32'd4), .OFF_CYC(32'd4),
		.GAP_CYC(32'd10)) i_dut (
		.clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_data(rx_data),
		.rx_eof(rx_eof), .rx_crc_ok(rx_crc_ok), .app_ready(app_ready),
		.err_detect(err_detect), .tx_pres(tx_pres), .tx_async(tx_async),
		.tx_legacy_en(tx_legacy_en), .pdo_valid(pdo_valid), .pdo_data(pdo_data),
		.cycle_start(cycle_start), .ident_req(ident_req), .nmt_state(nmt_state),
		.module_status_led(led));
	// pdo pulses are taken mid-cycle, clear of the launching edge
	always @(negedge clk)
		if (pdo_valid === 1'b1)
			got_q.push_back(pdo_data);
	function logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : xs
	function logic [6:0] cmd(input logic [7:0] c);
		case (c)
			CMD_RESET: return ST_NOT_ACTIVE;
			CMD_STOP: return es inside {ST_PREOP2, ST_READY, ST_OPER} ? ST_STOPPED : es;
			CMD_START: return es == ST_READY ? ST_OPER : es;
			CMD_PREOP2: return es inside {ST_OPER, ST_STOPPED} ? ST_PREOP2 : es;
			default: return es;
		endcase
	endfunction : cmd
	task chk(input logic [7:0] g, e, input string m);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: %s %h expected %h", $time, m, g, e);
		end
	endtask : chk
	task chk_st(input logic [6:0] g, e);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: state %h expected %h", $time, g, e);
		end
	endtask : chk_st
	task stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	task wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt
	task automatic fr(input logic [6:0] mt, input logic [7:0] dst, d0, d1, input logic [1:0] bad);
		logic ok, inv, ps, pa, pi;
		logic [31:0] f;
		ok = bad == 2'h0 && mt inside {MT_SOC, MT_PREQ, MT_PRES, MT_SOA, MT_ASND};
		f = xs();
		// data bytes leave before the crc verdict; only operational keeps them
		if (bad[0] == 1'b0 && es == ST_OPER && (mt == MT_PRES || (mt == MT_PREQ && dst == ME))) begin
			exp_q.push_back(d0);
			exp_q.push_back(d1);
			for (int i = 19; i < 23; i++)
				exp_q.push_back(f[8*(i%4)+:8] ^ 8'(i));
		end
		inv = ok && mt == MT_SOA && d0 != SVC_NONE && d1 == ME;
		ps = ok && mt == MT_PREQ && dst == ME && es inside {ST_READY, ST_OPER};
		pa = inv && !(es inside {ST_NOT_ACTIVE, ST_BASIC_ETH});
		pi = inv && es inside {ST_PREOP1, ST_PREOP2};
		if (ok && mt != MT_ASND && es == ST_BASIC_ETH)
			es = ST_PREOP1;
		else if (ok && es == ST_NOT_ACTIVE && mt inside {MT_SOC, MT_SOA})
			es = ST_PREOP1;
		else if (ok && mt == MT_SOC && es == ST_PREOP1)
			es = ST_PREOP2;
		else if (ok && mt == MT_ASND && d0 == SVC_NMT_CMD && dst inside {ME, NODE_BCAST})
			es = cmd(d1);
		i_mn.send(mt, dst, d0, d1, bad, f);
		wt(1);
		chk(tx_pres, ps, "pres");
		chk(tx_async, pa, "async");
		chk(ident_req, pi, "ident");
		chk(cycle_start, ok && mt == MT_SOC, "cycle");
		chk_st(nmt_state, es);
		chk(8'(got_q.size()), 8'(exp_q.size()), "pdo count");
		while (exp_q.size() > 0 && got_q.size() > 0)
			chk(got_q.pop_front(), exp_q.pop_front(), "pdo");
		got_q.delete();
		exp_q.delete();
	endtask : fr
	task rdy();
		@(posedge clk);
		app_ready <= 1'b0;
		fr(MT_ASND, ME, SVC_NMT_CMD, CMD_EN_RDY, 2'h0);
		@(posedge clk);
		app_ready <= 1'b1;
		wt(4);
		es = ST_READY;
		chk_st(nmt_state, es);
	endtask : rdy
	// count lit cycles over one whole pattern period
	task led_chk(input int n);
		int h, i;
		h = 0;
		i = 0;
		while (led !== 1'b1 && i < 200) begin
			wt(1);
			i++;
		end
		repeat (8 * n + 6) begin
			if (led === 1'b1)
				h++;
			wt(1);
		end
		chk(8'(h), 8'(4 * n), "led on cycles");
	endtask : led_chk
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			stop_test();
		end
	end
	initial begin
		rst = 1'b1;
		app_ready = 1'b1;
		err_detect = 1'b0;
		es = ST_NOT_ACTIVE;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		wt(1);
		chk_st(nmt_state, es);
		fr(MT_SOC, NODE_BCAST, 8'h00, 8'h00, 2'h1);
		fr(MT_SOC, NODE_BCAST, 8'h00, 8'h00, 2'h2);
		fr(7'h02, NODE_BCAST, 8'h00, 8'h00, 2'h0);
		fr(MT_PREQ, ME, 8'h00, 8'h00, 2'h0);
		fr(MT_PRES, NODE_BCAST, 8'h00, 8'h00, 2'h0);
		wt(100);
		chk_st(nmt_state, es);
		wt(30);
		es = ST_BASIC_ETH;
		chk_st(nmt_state, es);
		chk(tx_legacy_en, 1'b1, "legacy");
		fr(MT_PREQ, 8'h02, 8'h00, 8'h00, 2'h0);
		chk(tx_legacy_en, 1'b0, "legacy");
		fr(MT_ASND, NODE_BCAST, SVC_NMT_CMD, CMD_RESET, 2'h0);
		fr(MT_SOA, NODE_BCAST, SVC_NONE, 8'h00, 2'h0);
		fr(MT_SOA, NODE_BCAST, 8'h01, 8'h02, 2'h0);
		fr(MT_SOA, NODE_BCAST, 8'h01, ME, 2'h0);
		fr(MT_SOA, NODE_BCAST, SVC_NONE, 8'h00, 2'h0);
		fr(MT_PREQ, ME, 8'h00, 8'h00, 2'h0);
		led_chk(1);
		fr(MT_SOC, NODE_BCAST, 8'h00, 8'h00, 2'h0);
		fr(MT_PREQ, ME, 8'h00, 8'h00, 2'h0);
		fr(MT_SOA, NODE_BCAST, 8'h01, ME, 2'h0);
		led_chk(2);
		rdy();
		fr(MT_PREQ, ME, 8'h00, 8'h00, 2'h0);
		fr(MT_PREQ, 8'(xs()) | 8'h02, 8'h00, 8'h00, 2'h0);
		fr(MT_SOA, NODE_BCAST, 8'h01, ME, 2'h0);
		led_chk(3);
		@(posedge clk);
		err_detect <= 1'b1;
		@(posedge clk);
		err_detect <= 1'b0;
		wt(3);
		es = ST_PREOP1;
		chk_st(nmt_state, es);
		fr(MT_SOC, NODE_BCAST, 8'h00, 8'h00, 2'h0);
		rdy();
		fr(MT_ASND, ME, SVC_NMT_CMD, CMD_START, 2'h0);
		fr(MT_PREQ, ME, 8'h5A, 8'hC3, 2'h0);
		fr(MT_PRES, NODE_BCAST, 8'h3C, 8'hA5, 2'h2);
		fr(MT_PREQ, 8'h02, 8'h11, 8'h22, 2'h0);
		fr(MT_ASND, ME, SVC_NMT_CMD, CMD_STOP, 2'h0);
		fr(MT_ASND, ME, SVC_NMT_CMD, CMD_PREOP2, 2'h0);
		fr(MT_ASND, ME, SVC_NMT_CMD, CMD_STOP, 2'h0);
		fr(MT_ASND, ME, SVC_NMT_CMD, CMD_RESET, 2'h0);
		stop_test();
	end
endmodule : tb_plc_cn_nmt
`default_nettype wire
